// ==== core/nvram_host.sv ====
/*
 Host controller for an asynchronous SRAM-style nonvolatile byte memory.
 Assumes i_supply_ok is synchronous and low while the supply is below the
 write-inhibit level; pins are registered, so timing holds at the device.
*/
`timescale 1ns/1ns
`default_nettype none
module nvram_host #(
	parameter int STARTUP_CYCLES = nvram_host_pkg::STARTUP_CYC
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_supply_ok,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [nvram_host_pkg::ADDR_W-1:0] i_addr,
	input wire logic [nvram_host_pkg::DATA_W-1:0] i_wdata,
	output logic o_ready,
	output logic o_busy,
	output logic o_rvalid,
	output logic [nvram_host_pkg::DATA_W-1:0] o_rdata,
	output logic [nvram_host_pkg::ADDR_W-1:0] o_mem_addr,
	output logic o_mem_cs_n,
	output logic o_mem_we_n,
	output logic o_mem_oe_n,
	output logic [nvram_host_pkg::DATA_W-1:0] o_mem_dq,
	output logic o_mem_dq_oe,
	input wire logic [nvram_host_pkg::DATA_W-1:0] i_mem_dq
);
	import nvram_host_pkg::*;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	state_t state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] gap_reg;
	logic [CNT_W-1:0] hold_reg;

	assign o_ready = (state_reg == ST_IDLE) && (gap_reg == '0) && (hold_reg == '0) && i_supply_ok;
	assign o_busy = (state_reg != ST_IDLE);

	always_ff @(posedge i_clk)
	begin
		if (!i_nrst || !i_supply_ok)
		begin
			state_reg <= ST_STARTUP;
			cnt_reg <= '0;
		end
		else
		begin
			case (state_reg)
				ST_STARTUP:
				begin
					if (cnt_reg == CNT_W'(STARTUP_CYCLES - 1))
					begin
						state_reg <= ST_IDLE;
						cnt_reg <= '0;
					end
					else
						cnt_reg <= cnt_reg + 1'b1;
				end
				ST_IDLE:
				begin
					cnt_reg <= '0;
					if (o_ready && i_req)
						state_reg <= i_we ? ST_WRITE : ST_READ;
				end
				ST_READ:
				begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == CNT_W'(ACCESS_CYC - 1))
					begin
						state_reg <= ST_RECOVER;
						cnt_reg <= '0;
					end
				end
				ST_WRITE:
				begin
					cnt_reg <= cnt_reg + 1'b1;
					// Strobe low long enough for pulse, address and data setup
					if (cnt_reg == CNT_W'(WPULSE_CYC + 1))
					begin
						state_reg <= ST_RECOVER;
						cnt_reg <= '0;
					end
				end
				ST_RECOVER:
				begin
					// Lets the device release the bus before anything else
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == CNT_W'(RELEASE_CYC - 1))
					begin
						state_reg <= ST_IDLE;
						cnt_reg <= '0;
					end
				end
				default:
				begin
					state_reg <= ST_STARTUP;
					cnt_reg <= '0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Cycle spacing and strobe high time
	// ----------------------------------------
	// Spacing runs from each take, so reads and writes pace alike
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
			gap_reg <= '0;
		else if (o_ready && i_req)
			gap_reg <= CNT_W'(CYCLE_CYC - 1);
		else if (gap_reg != '0)
			gap_reg <= gap_reg - 1'b1;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
			hold_reg <= '0;
		// Reloaded through recovery, so strobes idle high past their minimum
		else if (state_reg == ST_RECOVER)
			hold_reg <= CNT_W'(HIGH_HOLD_CYC);
		else if (hold_reg != '0)
			hold_reg <= hold_reg - 1'b1;
	end

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	// Supply loss parks every strobe high at the first clock edge that sees it
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst || !i_supply_ok)
		begin
			o_mem_cs_n <= 1'b1;
			o_mem_we_n <= 1'b1;
			o_mem_oe_n <= 1'b1;
		end
		else
		begin
			o_mem_cs_n <= !((state_reg == ST_READ) || (state_reg == ST_WRITE)
				|| (o_ready && i_req));
			// Strobe falls one cycle after select and address: zero setup kept
			o_mem_we_n <= !((state_reg == ST_WRITE) && (cnt_reg <= CNT_W'(WPULSE_CYC)));
			o_mem_oe_n <= !(state_reg == ST_READ);
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			o_mem_addr <= '0;
			o_mem_dq <= '0;
		end
		else if (o_ready && i_req)
		begin
			o_mem_addr <= i_addr;
			o_mem_dq <= i_wdata;
		end
	end

	// Host drives the bus only through the write, released with strobe end
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst || !i_supply_ok)
			o_mem_dq_oe <= 1'b0;
		else
			o_mem_dq_oe <= (state_reg == ST_WRITE) && (cnt_reg <= CNT_W'(WPULSE_CYC));
	end

	// ----------------------------------------
	// Read capture
	// ----------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			o_rvalid <= 1'b0;
			o_rdata <= '0;
		end
		// Supply loss aborts a read: no pulse for data from an unpowered part
		else if (!i_supply_ok)
			o_rvalid <= 1'b0;
		else
		begin
			o_rvalid <= 1'b0;
			if ((state_reg == ST_READ) && (cnt_reg == CNT_W'(ACCESS_CYC - 1)))
			begin
				o_rdata <= i_mem_dq;
				o_rvalid <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== core/nvram_host_pkg.sv ====
/*
 Constants for the byte-wide nonvolatile memory host controller.
 Assumes a 250 MHz clock; all pin timing is counted in whole cycles.
*/
package nvram_host_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam int ADDR_W = 21;
	localparam int DATA_W = 8;
	// Startup delay after supply good
	localparam int STARTUP_MS = 2;
	localparam int STARTUP_CYC = (STARTUP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Least times, rounded up to cycles
	localparam int CYCLE_NS = 35;
	localparam int CYCLE_CYC = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WPULSE_NS = 15;
	localparam int WPULSE_CYC = (WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_TO_WEND_NS = 20;
	localparam int ADDR_TO_WEND_CYC = (ADDR_TO_WEND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DATA_SETUP_NS = 10;
	localparam int DATA_SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HIGH_HOLD_NS = 2;
	localparam int HIGH_HOLD_CYC = (HIGH_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Read: address access time plus one cycle to register the data
	localparam int ACCESS_NS = 35;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	// Release time of device outputs before the host drives the bus
	localparam int RELEASE_NS = 15;
	localparam int RELEASE_CYC = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 20;
	typedef enum logic [2:0] {
		ST_STARTUP = 3'h0,
		ST_IDLE = 3'h1,
		ST_READ = 3'h2,
		ST_WRITE = 3'h3,
		ST_RECOVER = 3'h4
	} state_t;
endpackage

// ==== tb/nvram_dev_model.sv ====
/* Byte memory model on the pins.
 No clock; write data taken from the host register. */
`timescale 1ns/1ns
`default_nettype none
module nvram_dev_model (
	input wire logic pwr, cs_n, we_n, oe_n,
	input wire logic [20:0] a,
	input wire logic [7:0] d,
	output logic [7:0] q = 8'h00
);
	logic [7:0] m [int];
	wire logic wr = !cs_n && !we_n;
	wire logic rd = !cs_n && !oe_n && we_n;
	always @(negedge wr) if (pwr && !$isunknown(a)) m[a] = d;
	// Released bus flips, so a stale byte never matches
	always @(rd or a) q <= #12 rd && m.exists(a) ? m[a] : ~q;
endmodule
`default_nettype wire

// ==== tb/nvram_host_properties.sv ====
/* Pin checker for nvram_host.
 Sees top ports only; bound from the bench. */
`timescale 1ns/1ns
`default_nettype none
module nvram_host_props #(
	parameter int STARTUP_CYCLES = nvram_host_pkg::STARTUP_CYC
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_supply_ok,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic o_ready,
	input wire logic o_rvalid,
	input wire logic o_mem_cs_n,
	input wire logic o_mem_we_n,
	input wire logic o_mem_oe_n,
	input wire logic o_mem_dq_oe,
	input wire logic [7:0] o_mem_dq,
	input wire logic [20:0] o_mem_addr
);
	default clocking @(posedge i_clk); endclocking
	// Supply loss resets the strobes and bus enable, so checks pause with it
	default disable iff (!i_nrst || !i_supply_ok);
	logic [19:0] up_cnt_reg;
	// Edges since reset and supply both good; saturates
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst || !i_supply_ok)
			up_cnt_reg <= '0;
		else if (up_cnt_reg != 20'hFFFFF)
			up_cnt_reg <= up_cnt_reg + 1'b1;
	end
	property p_wait; o_ready |-> (up_cnt_reg >= 20'(STARTUP_CYCLES)); endproperty
	a_wait: assert property (p_wait) else $error("early ready");
	sequence s_pulse; !o_mem_cs_n ##1 !o_mem_we_n[*4]; endsequence
	property p_start; $rose(i_nrst && i_supply_ok) |-> (o_mem_cs_n && !o_ready)[*8]; endproperty
	a_start: assert property (p_start) else $error("early");
	property p_wr; o_ready && i_req && i_we |=> s_pulse; endproperty
	a_wr: assert property (p_wr) else $error("pulse");
	property p_rd; o_ready && i_req && !i_we |-> ##11 o_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("late");
	property p_dq;
		$fell(o_mem_we_n) |-> ($stable(o_mem_dq) && $stable(o_mem_addr))[*5];
	endproperty
	a_dq: assert property (p_dq) else $error("moved");
	property p_oe; !o_mem_we_n |-> o_mem_oe_n && o_mem_dq_oe; endproperty
	a_oe: assert property (p_oe) else $error("oe");
	property p_we; !o_mem_oe_n |-> o_mem_we_n && !o_mem_dq_oe; endproperty
	a_we: assert property (p_we) else $error("we");
	property p_gap; $fell(o_mem_cs_n) |=> (!$fell(o_mem_cs_n))[*8]; endproperty
	a_gap: assert property (p_gap) else $error("gap");
	property p_high; $rose(o_mem_we_n) |=> o_mem_we_n; endproperty
	a_high: assert property (p_high) else $error("high");
endmodule
`default_nettype wire

// ==== tb/test_nvram_host.sv ====
/* Bench for nvram_host.
 Drives the user side; a memory model answers on the pins. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_nvram_host;
	import nvram_host_pkg::*;
	localparam int SU = 20;
	logic i_clk = 0, i_nrst = 0, i_supply_ok = 1, i_req = 0, i_we = 0;
	logic o_ready, o_busy, o_rvalid, o_mem_cs_n, o_mem_we_n, o_mem_oe_n, o_mem_dq_oe;
	logic [ADDR_W-1:0] i_addr = '0, o_mem_addr, adr [8];
	logic [DATA_W-1:0] i_wdata = '0, o_rdata, o_mem_dq, i_mem_dq, dev_q, e, exp_q [$], ref_m [int];
	int seed = 21688, n_errors = 0, n_tests = 0;
	nvram_host #(.STARTUP_CYCLES(SU)) dut (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_supply_ok(i_supply_ok),
		.i_req(i_req),
		.i_we(i_we),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.o_ready(o_ready),
		.o_busy(o_busy),
		.o_rvalid(o_rvalid),
		.o_rdata(o_rdata),
		.o_mem_addr(o_mem_addr),
		.o_mem_cs_n(o_mem_cs_n),
		.o_mem_we_n(o_mem_we_n),
		.o_mem_oe_n(o_mem_oe_n),
		.o_mem_dq(o_mem_dq),
		.o_mem_dq_oe(o_mem_dq_oe),
		.i_mem_dq(i_mem_dq)
	);
	nvram_dev_model mem (.pwr(i_supply_ok), .cs_n(o_mem_cs_n), .we_n(o_mem_we_n),
		.oe_n(o_mem_oe_n), .a(o_mem_addr), .d(o_mem_dq), .q(dev_q));
	assign i_mem_dq = o_mem_dq_oe ? o_mem_dq : dev_q;
	initial forever #2 i_clk = ~i_clk;
	always @(posedge i_clk)
	begin
		if (o_rvalid === 1'b1)
		begin
			e = exp_q.pop_front();
			`CHK("rdata", e, o_rdata)
		end
	end
	// Request stays up between ops; refused while not ready
	task automatic op(input logic w, input logic [20:0] ad, input logic [7:0] d);
		i_req <= 1;
		i_we <= w;
		i_addr <= ad;
		i_wdata <= d;
		do @(negedge i_clk); while (o_ready !== 1'b1);
		@(posedge i_clk);
		if (w) ref_m[ad] = d;
		else exp_q.push_back(ref_m[ad]);
	endtask
	task automatic boot(input string s);
		int n = 0;
		while (o_ready !== 1'b1 && n < 99)
		begin
			@(negedge i_clk);
			n++;
		end
		`CHK(s, 1'b1, n >= SU && n <= SU + 3)
		`CHK("busy", 1'b0, o_busy)
		@(posedge i_clk);
		$display("test %s done", s);
	endtask
	task automatic test_done;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge i_clk);
		i_nrst <= 1;
		boot("startup");
		for (int k = 0; k < 8; k++)
		begin
			adr[k] = k < 2 ? {21{k[0]}} : 21'($random(seed));
			op(1, adr[k], 8'($random(seed)));
		end
		for (int k = 0; k < 8; k++) op(0, adr[k], 8'h00);
		i_req <= 0;
		while (exp_q.size() > 0) @(posedge i_clk);
		$display("test write read done");
		i_supply_ok <= 0;
		i_req <= 1;
		repeat (2) @(posedge i_clk);
		`CHK("ready", 1'b0, o_ready)
		`CHK("busy", 1'b1, o_busy)
		`CHK("cs_n", 1'b1, o_mem_cs_n)
		i_supply_ok <= 1;
		i_req <= 0;
		boot("restart");
		op(0, adr[1], 8'h00);
		op(0, adr[5], 8'h00);
		i_req <= 0;
		while (exp_q.size() > 0) @(posedge i_clk);
		$display("test restart read done");
		test_done;
	end
	initial
	begin
		#20000;
		n_errors++;
		test_done;
	end
endmodule
bind nvram_host nvram_host_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk (
	.i_clk(i_clk),
	.i_nrst(i_nrst),
	.i_supply_ok(i_supply_ok),
	.i_req(i_req),
	.i_we(i_we),
	.o_ready(o_ready),
	.o_rvalid(o_rvalid),
	.o_mem_cs_n(o_mem_cs_n),
	.o_mem_we_n(o_mem_we_n),
	.o_mem_oe_n(o_mem_oe_n),
	.o_mem_dq_oe(o_mem_dq_oe),
	.o_mem_dq(o_mem_dq),
	.o_mem_addr(o_mem_addr)
);
`default_nettype wire
